// [core/pci_cfg_tail.sv]
// Configuration header tail: expansion ROM base, bus needs, interrupt map, power management.
`timescale 1ns/1ps
`include "pci_cfg_tail_cfg.svh"
// Function
// - ROM base keeps bits 31:16 and decode-enable bit 0 writable, bits 15:1 read zero (64 KB).
// - ROM decode-enable bit gates claiming accesses inside the ROM window.
// - Max-latency byte 31:24 is read-only, loaded from EEPROM after reset.
// - Min-grant byte 23:16 is read-only, loaded from EEPROM after reset.
// - Max-latency and min-grant values count quarter-microsecond units.
// - Interrupt-pin byte reads constant 01h, first PCI interrupt line.
// - Interrupt-line byte is read/write, stored without interpretation.
// - D3-cold PME support bit shows the strap latched after each reset release.
// - PME support bits for D3-hot, D2, D1, D0 read 1110.
// - D2 and D1 support bits read one; three bits below read zero.
// - Device-specific-initialization flag reads one.
// - Auxiliary-power flag reads one only when the latched strap is high.
// - PME-clock flag reads zero.
// - Version field reads 001.
// - Next-capability pointer reads 00h.
// - Capability identifier byte reads 01h.
// - Capability word is read-only; writes change nothing.
// - Data, bridge, scale and select fields of control word read zero.
// - PME status sets on wake in low power, cleared by writing one.
// - PME enable bit gates signalling of a wake event.
// - Two-bit power state is writable and reads back, D0..D3 as 0..3.
// - Reserved bits 7:2 of the control word read zero.
module pci_cfg_tail (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_ack,
    input  wire logic        ee_load,
    input  wire logic [7:0]  ee_max_latency,
    input  wire logic [7:0]  ee_min_grant,
    input  wire logic        cold_wake_strap_pin,
    input  wire logic        wake_event,
    input  wire logic        rom_req,
    input  wire logic [31:0] rom_addr,
    output logic             rom_claim,
    output logic             pme_wake
);

    // ==========================================
    // Reset release and pin synchronisers
    logic       rst_meta;
    logic       rst_n;
    logic [2:0] strap_sync;
    logic [2:0] wake_sync;
    logic [2:0] strap_fill;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_sync <= 3'h0;
            wake_sync  <= 3'h0;
            strap_fill <= 3'h0;
        end else begin
            strap_sync <= {strap_sync[1:0], cold_wake_strap_pin};
            wake_sync  <= {wake_sync[1:0], wake_event};
            strap_fill <= {strap_fill[1:0], 1'b1};
        end
    end

    // A level counts only once the second and third stages agree.
    // The fill marker keeps the reset zeros of the stages from passing as an agreed
    // strap level, which would latch a low strap on every board.
    wire strap_stable = strap_fill[2] && (strap_sync[1] == strap_sync[2]);
    wire wake_seen    = wake_sync[1] & wake_sync[2];

    // ==========================================
    // Byte-lane merge used by the ROM base register and the PME status clear
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    wire wr_rom  = cfg_wr && (cfg_addr == `OFS_ROM_BASE);
    wire wr_irq  = cfg_wr && (cfg_addr == `OFS_BUS_IRQ_MAP);
    wire wr_pmcs = cfg_wr && (cfg_addr == `OFS_PM_CTRL_STAT);
    wire [31:0] pmcs_wr_val = merge_bytes(32'h0000_0000, cfg_wdata, cfg_be);

    // ==========================================
    // Strap capture after reset release
    logic strap_taken;
    logic cold_pme_support;

    // The strap is caught once, after release, so a later change on the pin is ignored.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_taken      <= 1'b0;
            cold_pme_support <= 1'b0;
        end else if (!strap_taken && strap_stable) begin
            strap_taken      <= 1'b1;
            cold_pme_support <= strap_sync[2];
        end
    end

    // ==========================================
    // Expansion ROM base
    logic [15:0] rom_base;
    logic        rom_dec_en;
    wire  [31:0] rom_word = {rom_base, 15'h0000, rom_dec_en};
    wire  [31:0] rom_wr_val = merge_bytes(rom_word, cfg_wdata, cfg_be);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_base   <= 16'h0000;
            rom_dec_en <= 1'b0;
        end else if (wr_rom) begin
            rom_base   <= rom_wr_val[31:`ROM_BASE_LSB];
            rom_dec_en <= rom_wr_val[`ROM_DEC_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_claim <= 1'b0;
        end else begin
            rom_claim <= rom_req && rom_dec_en &&
                         (rom_addr[31:`ROM_BASE_LSB] == rom_base);
        end
    end

    // ==========================================
    // Bus needs and interrupt map
    // Latency and grant bytes count quarter microseconds; they are passed through untouched.
    logic [7:0] max_latency;
    logic [7:0] min_grant;
    logic [7:0] int_line;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            max_latency <= `RST_BYTE;
            min_grant   <= `RST_BYTE;
        end else if (ee_load) begin
            max_latency <= ee_max_latency;
            min_grant   <= ee_min_grant;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_line <= `RST_BYTE;
        end else if (wr_irq && cfg_be[0]) begin
            int_line <= cfg_wdata[7:0];
        end
    end

    // ==========================================
    // Power management control and status
    pci_cfg_tail_pkg::power_state_e power_state;
    logic pme_status;
    logic pme_enable;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_state <= pci_cfg_tail_pkg::PS_D0;
        end else if (wr_pmcs && cfg_be[0]) begin
            power_state <= pci_cfg_tail_pkg::power_state_e'(cfg_wdata[1:0]);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pme_enable <= 1'b0;
        end else if (wr_pmcs && cfg_be[1]) begin
            pme_enable <= cfg_wdata[`PME_ENABLE_BIT];
        end
    end

    // A wake in a low-power state sets the status even with notification off;
    // a set in the same cycle as a write-one clear wins.
    wire wake_hit  = wake_seen && (power_state != pci_cfg_tail_pkg::PS_D0);
    wire pme_clear = wr_pmcs && pmcs_wr_val[`PME_STATUS_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pme_status <= 1'b0;
        end else if (wake_hit) begin
            pme_status <= 1'b1;
        end else if (pme_clear) begin
            pme_status <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pme_wake <= 1'b0;
        end else begin
            pme_wake <= pme_status && pme_enable;
        end
    end

    // ==========================================
    // Read data
    wire [31:0] bus_irq_word = {max_latency, min_grant, `INT_PIN_VALUE, int_line};
    wire [31:0] cap_word = {cold_pme_support, `PM_SUPPORT_HOT, `PM_D2_D1_SUPPORT,
                            3'h0, `PM_DSI_VALUE, cold_pme_support,
                            `PM_CLOCK_VALUE, `PM_VERSION,
                            `PM_NEXT_PTR, `PM_CAP_ID};
    wire [31:0] pmcs_word = {16'h0000, pme_status, 6'h00, pme_enable,
                             6'h00, power_state};

    logic [31:0] next_rdata;

    always_comb begin
        case (cfg_addr)
            `OFS_ROM_BASE:     next_rdata = rom_word;
            `OFS_BUS_IRQ_MAP:  next_rdata = bus_irq_word;
            `OFS_PM_CAP_HDR:   next_rdata = cap_word;
            `OFS_PM_CTRL_STAT: next_rdata = pmcs_word;
            default:           next_rdata = `RST_WORD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= `RST_WORD;
            cfg_ack   <= 1'b0;
        end else begin
            cfg_ack <= cfg_rd | cfg_wr;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // ==========================================
    // Checks
    sequence wake_in_low_power;
        wake_seen && (power_state != pci_cfg_tail_pkg::PS_D0);
    endsequence

    sequence pmcs_read;
        cfg_rd && (cfg_addr == `OFS_PM_CTRL_STAT);
    endsequence

    sequence cap_read;
        cfg_rd && (cfg_addr == `OFS_PM_CAP_HDR);
    endsequence

    sequence bus_irq_read;
        cfg_rd && (cfg_addr == `OFS_BUS_IRQ_MAP);
    endsequence

    sequence rom_read;
        cfg_rd && (cfg_addr == `OFS_ROM_BASE);
    endsequence

    AST_ROM_LOW_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_rd && (cfg_addr == `OFS_ROM_BASE) |=> cfg_rdata[15:1] == 15'h0000)
        else $error("ROM base low bits not zero.");

    AST_ROM_CLAIM: assert property (@(posedge clk) disable iff (!rst_n)
        rom_claim |-> $past(rom_dec_en) && $past(rom_req))
        else $error("ROM access claimed while decode disabled.");

    AST_EE_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        ee_load |=> max_latency == $past(ee_max_latency) && min_grant == $past(ee_min_grant))
        else $error("EEPROM bus needs not reflected.");

    AST_BUS_NEEDS_RO: assert property (@(posedge clk) disable iff (!rst_n)
        !ee_load |=> $stable(max_latency) && $stable(min_grant))
        else $error("Bus needs changed without an EEPROM load.");

    AST_BUS_IRQ_READ: assert property (@(posedge clk) disable iff (!rst_n)
        bus_irq_read |=> cfg_rdata[31:16] == $past({max_latency, min_grant}) &&
                         cfg_rdata[7:0] == $past(int_line))
        else $error("Bus needs word read back wrong.");

    AST_INT_PIN: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_rd && (cfg_addr == `OFS_BUS_IRQ_MAP) |=> cfg_rdata[15:8] == 8'h01)
        else $error("Interrupt pin byte wrong.");

    AST_INT_LINE: assert property (@(posedge clk) disable iff (!rst_n)
        wr_irq && cfg_be[0] |=> int_line == $past(cfg_wdata[7:0]))
        else $error("Interrupt line not stored.");

    AST_INT_LINE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !(wr_irq && cfg_be[0]) |=> $stable(int_line))
        else $error("Interrupt line changed without a write.");

    AST_CAP_WORD: assert property (@(posedge clk) disable iff (!rst_n)
        cap_read |=> cfg_rdata[30:21] == 10'h3B1 && cfg_rdata[19:0] == 20'h1_0001 &&
                     cfg_rdata[31] == cfg_rdata[20])
        else $error("Capability word wrong.");

    AST_PME_SET: assert property (@(posedge clk) disable iff (!rst_n)
        wake_in_low_power |=> pme_status)
        else $error("PME status not set by wake.");

    AST_PME_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        pme_status && pme_clear && !wake_hit |=> !pme_status)
        else $error("PME status not cleared by write one.");

    AST_PME_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
        pme_status && pme_enable ##1 (pme_status && pme_enable) |-> pme_wake)
        else $error("Wake output not driven.");

    AST_PMCS_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        pmcs_read |=> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[14:9] == 6'h00 &&
                      cfg_rdata[7:2] == 6'h00)
        else $error("Reserved control bits not zero.");

    AST_PSTATE: assert property (@(posedge clk) disable iff (!rst_n)
        wr_pmcs && cfg_be[0] |=> power_state == $past(cfg_wdata[1:0]))
        else $error("Power state not written.");

    AST_PSTATE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !(wr_pmcs && cfg_be[0]) |=> $stable(power_state))
        else $error("Power state changed without a write.");

    AST_PMCS_READ: assert property (@(posedge clk) disable iff (!rst_n)
        pmcs_read |=> cfg_rdata[15] == $past(pme_status) &&
                      cfg_rdata[8] == $past(pme_enable) &&
                      cfg_rdata[1:0] == $past(power_state))
        else $error("Control word read back wrong.");

    AST_PME_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
        wr_pmcs && cfg_be[1] |=> pme_enable == $past(cfg_wdata[`PME_ENABLE_BIT]))
        else $error("PME enable not written.");

    AST_PME_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        pme_status && !pme_clear |=> pme_status)
        else $error("PME status lost without a clear.");

    AST_PME_D0_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
        wake_seen && power_state == pci_cfg_tail_pkg::PS_D0 && !pme_status |=> !pme_status)
        else $error("PME status set by a wake in D0.");

    AST_PME_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        !(pme_status && pme_enable) |=> !pme_wake)
        else $error("Wake output not released.");

    AST_ROM_DEC_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !rom_dec_en |=> !rom_claim)
        else $error("ROM access claimed with decode off.");

    AST_ROM_BASE_WR: assert property (@(posedge clk) disable iff (!rst_n)
        wr_rom && cfg_be[3] && cfg_be[2] |=> rom_base == $past(cfg_wdata[31:16]))
        else $error("ROM base not written.");

    AST_ROM_READ: assert property (@(posedge clk) disable iff (!rst_n)
        rom_read |=> cfg_rdata[31:16] == $past(rom_base) &&
                     cfg_rdata[0] == $past(rom_dec_en))
        else $error("ROM base read back wrong.");

    AST_CAP_STRAP: assert property (@(posedge clk) disable iff (!rst_n)
        cap_read |=> cfg_rdata[31] == $past(cold_pme_support) &&
                     cfg_rdata[20] == $past(cold_pme_support))
        else $error("Capability strap bits wrong.");

    AST_STRAP_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
        strap_taken |=> strap_taken && $stable(cold_pme_support))
        else $error("Latched strap changed after capture.");

endmodule : pci_cfg_tail

// [core/pci_cfg_tail_cfg.svh]
// Offsets, field positions and fixed values of the configuration header tail.
`ifndef PCI_CFG_TAIL_CFG_SVH
`define PCI_CFG_TAIL_CFG_SVH

// ==========================================
// Register offsets
`define OFS_ROM_BASE      8'h30
`define OFS_BUS_IRQ_MAP   8'h3C
`define OFS_PM_CAP_HDR    8'hDC
`define OFS_PM_CTRL_STAT  8'hE0

// ==========================================
// Field positions
`define ROM_BASE_LSB      16
`define ROM_DEC_EN_BIT    0
`define PME_STATUS_BIT    15
`define PME_ENABLE_BIT    8

// ==========================================
// Fixed values
`define INT_PIN_VALUE     8'h01
`define PM_SUPPORT_HOT    4'hE
`define PM_D2_D1_SUPPORT  2'h3
`define PM_DSI_VALUE      1'h1
`define PM_CLOCK_VALUE    1'h0
`define PM_VERSION        3'h1
`define PM_NEXT_PTR       8'h00
`define PM_CAP_ID         8'h01

// ==========================================
// Reset values
`define RST_WORD          32'h0000_0000
`define RST_BYTE          8'h00
`define RST_PSTATE        2'h0

`endif

// [core/pci_cfg_tail_pkg.sv]
// Types shared by the configuration header tail.
package pci_cfg_tail_pkg;

    // ==========================================
    // Power state encoding
    typedef enum logic [1:0] {
        PS_D0 = 2'h0,
        PS_D1 = 2'h1,
        PS_D2 = 2'h2,
        PS_D3 = 2'h3
    } power_state_e;

endpackage : pci_cfg_tail_pkg

// [tb/host_model.sv]
// Host bridge model that issues configuration reads and writes to the header tail.
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk,
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata,
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic      [7:0]  cfg_addr,
    output logic      [3:0]  cfg_be,
    output logic      [31:0] cfg_wdata
);
    initial begin
        cfg_rd    = 1'b0;
        cfg_wr    = 1'b0;
        cfg_addr  = 8'h00;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end

    // ==========================================
    // Access
    // Address and data are inverted once the acknowledge has been taken, so a late
    // sample of the released bus cannot match by accident.
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q, output logic ok);
        ok = 1'b0;
        @(posedge clk);
        cfg_rd    <= ~wr;
        cfg_wr    <= wr;
        cfg_addr  <= a;
        cfg_be    <= be;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_rd    <= 1'b0;
        cfg_wr    <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            ok = (cfg_ack === 1'b1);
        end
        q = cfg_rdata;
        cfg_addr  <= ~a;
        cfg_wdata <= ~d;
    endtask : access
endmodule : host_model

// [tb/testbench.sv]
// Self-checking testbench of the configuration header tail.
`timescale 1ns/1ps
module testbench;
    logic        clk;
    logic        reset_n;
    logic        cfg_rd;
    logic        cfg_wr;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic        cfg_ack;
    logic        ee_load;
    logic [7:0]  ee_max_latency;
    logic [7:0]  ee_min_grant;
    logic        cold_wake_strap_pin;
    logic        wake_event;
    logic        rom_req;
    logic [31:0] rom_addr;
    logic        rom_claim;
    logic        pme_wake;
    int          failures;
    int          checks_done;

    pci_cfg_tail dut_u (.clk, .reset_n, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
        .cfg_rdata, .cfg_ack, .ee_load, .ee_max_latency, .ee_min_grant,
        .cold_wake_strap_pin, .wake_event, .rom_req, .rom_addr, .rom_claim, .pme_wake);
    host_model host_u (.clk, .cfg_ack, .cfg_rdata, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be,
        .cfg_wdata);

    // ==========================================
    // Checking
    task automatic check32(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask : check32
    task automatic check1(input logic g, input logic e, input string m);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: %s got %b expected %b", $time, m, g, e);
        end
    endtask : check1
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        logic        ok;
        host_u.access(1'b1, a, be, d, q, ok);
        check1(ok, 1'b1, "write ack");
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] q;
        logic        ok;
        host_u.access(1'b0, a, 4'hF, 32'h0000_0000, q, ok);
        check1(ok, 1'b1, "read ack");
        check32(q, e, m);
    endtask : rd
    task automatic rom_try(input logic [31:0] a, input logic e);
        @(posedge clk);
        rom_req  <= 1'b1;
        rom_addr <= a;
        @(posedge clk);
        rom_req  <= 1'b0;
        rom_addr <= ~a;
        #1 check1(rom_claim, e, "rom claim");
    endtask : rom_try
    task automatic wake_pulse();
        @(posedge clk);
        wake_event <= 1'b1;
        repeat (8) @(posedge clk);
        wake_event <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : wake_pulse
    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : do_reset

    // ==========================================
    // Scenarios
    task automatic t_rom();
        wr(8'h30, 4'hF, 32'hFFFF_FFFF);
        rd(8'h30, 32'hFFFF_0001, "rom base");
        rom_try(32'hFFFF_1234, 1'b1);
        rom_try(32'h1234_0000, 1'b0);
        wr(8'h30, 4'hF, 32'hABCD_0000);
        rom_try(32'hABCD_0010, 1'b0);
        wr(8'h30, 4'hF, 32'hABCD_0001);
        rom_try(32'hABCD_FFFC, 1'b1);
        $display("test rom done");
    endtask : t_rom
    task automatic t_bus_needs();
        rd(8'h3C, 32'h0000_0100, "bus needs reset");
        @(posedge clk);
        ee_load        <= 1'b1;
        ee_max_latency <= 8'h1C;
        ee_min_grant   <= 8'h08;
        @(posedge clk);
        ee_load        <= 1'b0;
        wr(8'h3C, 4'hF, 32'h0000_005A);
        rd(8'h3C, 32'h1C08_015A, "bus needs");
        wr(8'h3C, 4'hE, 32'hFFFF_FF11);
        rd(8'h3C, 32'h1C08_015A, "read-only lanes");
        rd(8'h40, 32'h0000_0000, "unmapped");
        $display("test bus_needs done");
    endtask : t_bus_needs
    task automatic t_cap(input logic [31:0] e);
        rd(8'hDC, e, "capability");
        wr(8'hDC, 4'hF, ~e);
        rd(8'hDC, e, "capability after write");
        $display("test capability done");
    endtask : t_cap
    task automatic t_pm_state();
        wr(8'hE0, 4'hF, 32'hFFFF_FFFF);
        rd(8'hE0, 32'h0000_0103, "control word");
        for (int s = 0; s < 4; s++) begin
            wr(8'hE0, 4'h1, {30'h0, s[1:0]});
            rd(8'hE0, {30'h40, s[1:0]}, "power state");
        end
        $display("test pm_state done");
    endtask : t_pm_state
    task automatic t_wake();
        wr(8'hE0, 4'h3, 32'h0000_0100);
        wake_pulse();
        rd(8'hE0, 32'h0000_0100, "wake in D0");
        check1(pme_wake, 1'b0, "no wake in D0");
        wr(8'hE0, 4'h3, 32'h0000_0101);
        wake_pulse();
        check1(pme_wake, 1'b1, "wake driven");
        rd(8'hE0, 32'h0000_8101, "status set");
        wr(8'hE0, 4'h3, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 check1(pme_wake, 1'b0, "wake gated");
        rd(8'hE0, 32'h0000_8001, "status kept");
        wr(8'hE0, 4'h3, 32'h0000_8001);
        rd(8'hE0, 32'h0000_0001, "status cleared");
        $display("test wake done");
    endtask : t_wake

    // ==========================================
    // Run control
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200us;
        failures++;
        final_report();
    end
    initial begin
        failures = 0;
        checks_done = 0;
        reset_n = 1'b0;
        ee_load = 1'b0;
        ee_max_latency = 8'h00;
        ee_min_grant = 8'h00;
        cold_wake_strap_pin = 1'b1;
        wake_event = 1'b0;
        rom_req = 1'b0;
        rom_addr = 32'h0000_0000;
        do_reset();
        t_bus_needs();
        t_rom();
        t_cap(32'hF631_0001);
        t_pm_state();
        t_wake();
        cold_wake_strap_pin <= 1'b0;
        do_reset();
        t_cap(32'h7621_0001);
        final_report();
    end
endmodule : testbench
